// file: bench/timer_port_mode_assertions.sv
// Checker for timer_port_mode, bound to its top-level ports.
// Assumes one-cycle register strobes and a settled mode before pin events.
`timescale 1ns/1ps
`default_nettype none
module timer_port_mode_assertions (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_baud_clk,
    input wire logic [7:0] i_p1_in,
    input wire logic [7:0] i_p2_in,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_p1_out,
    input wire logic [7:0] o_p1_oe,
    input wire logic [7:0] o_p2_out,
    input wire logic [7:0] o_p2_oe,
    input wire logic [7:0] o_irq_req
);
    // Shadow of the written configuration
    logic [7:0] mode;
    logic [7:0] dir;
    logic [3:0] baud;
    logic test_on;
    logic hs_out;
    logic hs_in;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= tpm_pkg::MODE_RESET;
            dir <= tpm_pkg::DIR_RESET;
            baud <= 4'h0;
        end else if (i_wr) begin
            case (i_addr)
                tpm_pkg::REG_MODE: mode <= i_wdata;
                tpm_pkg::REG_P1DIR: dir <= i_wdata;
                tpm_pkg::REG_CMD2: baud <= i_wdata[3:0];
                default: ;
            endcase
        end
    end
    assign test_on = mode[2:0] == tpm_pkg::P2_TEST && dir[4] && baud >= 4'h3;
    assign hs_out = mode[2:0] == tpm_pkg::P2_HS_OUT;
    assign hs_in = mode[2:0] == tpm_pkg::P2_HS_IN;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    sequence mode_wr_s;
        i_wr && i_addr == tpm_pkg::REG_MODE;
    endsequence
    sequence strobe_fall_s;
        $fell(i_p1_in[tpm_pkg::P1_STROBE]);
    endsequence
    property p2_dir_p;
        logic [7:0] d;
        (mode_wr_s ##0 (1'b1, d = i_wdata) ##1 !(i_wr && i_addr == tpm_pkg::REG_MODE)) |->
            ##1 o_p2_oe == (d[2:0] == 3'h5 ? 8'hff : d[2] ? 8'h00 : {{4{d[1]}}, {4{d[0]}}});
    endproperty
    AST_P2_DIRECTION: assert property (p2_dir_p)
        else $error("port 2 direction wrong after mode write");
    AST_TEST_BAUD: assert property (test_on && $past(test_on) |->
        o_p1_out[4] == $past(i_baud_clk) && o_p1_oe[4])
        else $error("baud clock not on port 1 bit 4");
    AST_P1_DIRECTION: assert property (mode == 8'h00 && $stable(mode) && $stable(dir) |->
        o_p1_oe == dir)
        else $error("port 1 enables differ from direction register");
    AST_HS_PINS: assert property ((hs_out || hs_in) && $stable(mode) |->
        o_p1_oe[1] && !o_p1_oe[0])
        else $error("handshake pin roles wrong");
    AST_OUT_FULL_LOW: assert property (hs_out && i_wr && i_addr == tpm_pkg::REG_PORT2 |->
        ##[1:3] !o_p1_out[1])
        else $error("full flag not lowered by port 2 write");
    AST_ACK_FULL_HIGH: assert property (hs_out ##0 strobe_fall_s |->
        ##[2:6] o_p1_out[1])
        else $error("full flag not raised by acknowledge");
    AST_STROBE_FULL_LOW: assert property (hs_in ##0 strobe_fall_s |->
        ##[2:6] !o_p1_out[1])
        else $error("input full not lowered by strobe");
    AST_SOFT_RESET: assert property ((hs_in || hs_out) && i_wr && i_addr == tpm_pkg::REG_CMD3
        && i_wdata[7] && i_wdata[0] |-> ##[1:3] o_p1_out[1])
        else $error("soft reset left full flag low");
    AST_IRQ_ONCE: assert property ($rose(o_irq_req[0]) |=> (!o_irq_req[0]) [*8])
        else $error("timer 1 request not a single pulse");
endmodule
bind timer_port_mode timer_port_mode_assertions chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_baud_clk(i_baud_clk),
    .i_p1_in(i_p1_in), .i_p2_in(i_p2_in), .o_rdata(o_rdata), .o_p1_out(o_p1_out),
    .o_p1_oe(o_p1_oe), .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe), .o_irq_req(o_irq_req));
`default_nettype wire

// file: bench/timer_port_mode_tb.sv
// Self-checking bench for timer_port_mode with a parallel peripheral.
// Assumes the package, design, checker and peripheral are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timer_port_mode_tb;
    localparam logic [3:0] T2 = 4'hb;
    localparam logic [3:0] T4 = 4'hd;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_baud_clk = 1'b0;
    logic baud_run = 1'b0;
    logic [7:0] o_rdata, o_p1_out, o_p1_oe, o_p2_out, o_p2_oe, o_irq_req;
    logic [7:0] p1_drv, p2_drv, p1_pin, p2_pin, c;
    logic [7:0] irq_seen = 8'h00;
    int n_mismatch = 0;
    int comparisons = 0;
    always #12.5 i_clk = ~i_clk;
    // Pin level is the design's value where it drives, else the peripheral's
    assign p1_pin = (o_p1_oe & o_p1_out) | (~o_p1_oe & p1_drv);
    assign p2_pin = (o_p2_oe & o_p2_out) | (~o_p2_oe & p2_drv);
    always @(posedge i_clk) if (baud_run) i_baud_clk <= ~i_baud_clk;
    // Requests are one-cycle pulses, so collect them
    always @(negedge i_clk) irq_seen = irq_seen | o_irq_req;
    timer_port_mode uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_wdata(i_wdata), .i_baud_clk(i_baud_clk), .i_p1_in(p1_pin),
        .i_p2_in(p2_pin), .o_rdata(o_rdata), .o_p1_out(o_p1_out), .o_p1_oe(o_p1_oe),
        .o_p2_out(o_p2_out), .o_p2_oe(o_p2_oe), .o_irq_req(o_irq_req));
    tpm_periph p (.i_clk(i_clk), .i_p1_pin(p1_pin), .i_p2_pin(p2_pin), .o_p1_drv(p1_drv),
        .o_p2_drv(p2_drv));
    task automatic stop_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(what, exp, o_rdata);
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        $display("unexpected run length: expected end, seen still running");
        stop_test();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        rchk("mode reset", tpm_pkg::REG_MODE, tpm_pkg::MODE_RESET);
        rchk("dir reset", tpm_pkg::REG_P1DIR, tpm_pkg::DIR_RESET);
        rchk("timer5 reset", tpm_pkg::REG_TIMER5, tpm_pkg::SAVE5_RESET);
        rchk("unmapped", 4'h7, 8'h00);
        wr(tpm_pkg::REG_P1DIR, 8'hc3);
        idle(2);
        chk("port1 oe", 8'hc3, o_p1_oe);
        rchk("dir", tpm_pkg::REG_P1DIR, 8'hc3);
        for (int i = 0; i < 8; i++) begin
            c = 8'(i);
            wr(tpm_pkg::REG_MODE, c);
            idle(2);
            chk("port2 oe",
                c[2] ? {8{c == 8'h05}} : {{4{c[1]}}, {4{c[0]}}}, o_p2_oe);
            rchk("mode", tpm_pkg::REG_MODE, c);
        end
        wr(tpm_pkg::REG_MODE, 8'h01);
        p.o_p2_drv <= 8'hc3;
        wr(tpm_pkg::REG_PORT2, 8'h5a);
        idle(4);
        rchk("port2 mixed", tpm_pkg::REG_PORT2, 8'hca);
        wr(tpm_pkg::REG_CMD2, 8'h03);
        wr(tpm_pkg::REG_P1DIR, 8'h10);
        wr(tpm_pkg::REG_MODE, 8'h07);
        baud_run = 1'b1;
        idle(12);
        chk("baud pin oe", 8'h10, o_p1_oe & 8'h10);
        baud_run = 1'b0;
        wr(tpm_pkg::REG_MODE, 8'h08);
        wr(tpm_pkg::REG_IEN_SET, 8'hff);
        wr(T2, 8'h05);
        repeat (3) p.pulse(tpm_pkg::P1_EV2, 3);
        idle(8);
        rchk("event count", T2, 8'h02);
        wr(tpm_pkg::REG_MODE, 8'h48);
        wr(T4, 8'h00);
        wr(T2, 8'h02);
        irq_seen = 8'h00;
        repeat (2) p.pulse(tpm_pkg::P1_EV2, 3);
        idle(10);
        chk("cascade levels", 8'h40, irq_seen & 8'h46);
        wr(tpm_pkg::REG_MODE, 8'h00);
        irq_seen = 8'h00;
        wr(tpm_pkg::REG_TIMER1, 8'h02);
        idle(30);
        chk("early request", 8'h00, irq_seen & 8'h01);
        idle(100);
        chk("timer1 request", 8'h01, irq_seen & 8'h01);
        rchk("enables", tpm_pkg::REG_IEN_SET, 8'hbe);
        wr(tpm_pkg::REG_MODE, 8'h20);
        wr(tpm_pkg::REG_TIMER5, 8'h03);
        idle(100);
        rchk("timer5 held", tpm_pkg::REG_TIMER5, 8'h00);
        // Middle pass leaves the level disabled: no request may appear
        for (int k = 0; k < 3; k++) begin
            if (k != 1) wr(tpm_pkg::REG_IEN_SET, 8'h80);
            irq_seen = 8'h00;
            p.pulse(tpm_pkg::P1_TRIG5, 2);
            idle(200);
            chk("timer5 request", k == 1 ? 8'h00 : 8'h80, irq_seen & 8'h80);
        end
        wr(tpm_pkg::REG_MODE, 8'hb0);
        wr(tpm_pkg::REG_TIMER5, 8'h01);
        wr(4'hc, 8'h12);
        p.pulse(tpm_pkg::P1_TRIG5, 2);
        idle(6);
        rchk("t3 preset", 4'hc, 8'hff);
        rchk("t5 preset", tpm_pkg::REG_TIMER5, 8'h01);
        wr(tpm_pkg::REG_MODE, 8'h05);
        p.auto_ack = 1'b1;
        for (int k = 0; k < 2; k++) begin
            p.ack_delay = k * 12;
            c = k ? 8'h5a : 8'ha5;
            wr(tpm_pkg::REG_IEN_SET, 8'h80);
            irq_seen = 8'h00;
            wr(tpm_pkg::REG_PORT2, c);
            idle(4);
            if (k) chk("full low", 8'h00, {7'h0, p1_pin[1]});
            idle(40);
            chk("taken data", c, p.taken);
            chk("full high", 8'h01, {7'h0, p1_pin[1]});
            chk("handshake level", 8'h80, irq_seen & 8'h80);
        end
        p.auto_ack = 1'b0;
        wr(tpm_pkg::REG_PORT2, 8'h11);
        idle(4);
        chk("full pending", 8'h00, {7'h0, p1_pin[1]});
        wr(tpm_pkg::REG_CMD3, 8'h81);
        idle(4);
        chk("full after soft reset", 8'h01, {7'h0, p1_pin[1]});
        wr(tpm_pkg::REG_MODE, 8'h04);
        p.o_p2_drv <= 8'h3c;
        p.drive(tpm_pkg::P1_STROBE, 1'b0);
        idle(6);
        chk("input full low", 8'h00, {7'h0, p1_pin[1]});
        p.drive(tpm_pkg::P1_STROBE, 1'b1);
        idle(6);
        p.o_p2_drv <= 8'hc3;
        idle(4);
        rchk("latched data", tpm_pkg::REG_PORT2, 8'h3c);
        idle(2);
        chk("input full high", 8'h01, {7'h0, p1_pin[1]});
        stop_test();
    end
endmodule
`default_nettype wire

// file: bench/tpm_periph.sv
// Parallel peripheral on the port 1 and port 2 pins.
// Assumes the bench feeds back resolved pin levels.
`timescale 1ns/1ps
`default_nettype none
module tpm_periph (
    input wire logic i_clk,
    input wire logic [7:0] i_p1_pin,
    input wire logic [7:0] i_p2_pin,
    output logic [7:0] o_p1_drv,
    output logic [7:0] o_p2_drv
);
    logic auto_ack = 1'b0;
    int ack_delay = 0;
    logic [7:0] taken = 8'h00;
    // Port 1 idles high, as if pulled up
    initial begin
        o_p1_drv = 8'hff;
        o_p2_drv = 8'h00;
    end
    task automatic drive(input int b, input logic v);
        @(posedge i_clk);
        o_p1_drv[b] <= v;
    endtask
    task automatic pulse(input int b, input int n);
        drive(b, 1'b0);
        repeat (n) @(posedge i_clk);
        drive(b, 1'b1);
    endtask
    // Reader takes data only after full goes low; delay models a slow reader
    always begin
        @(posedge i_clk);
        if (auto_ack && !i_p1_pin[tpm_pkg::P1_FULL]) begin
            repeat (ack_delay) @(posedge i_clk);
            taken = i_p2_pin;
            pulse(tpm_pkg::P1_STROBE, 2);
            repeat (8) @(posedge i_clk);
        end
    end
endmodule
`default_nettype wire

// file: verilog/tc_unit.sv
// One 8-bit down counter of the timer bank.
// Assumes load and decrement strobes come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module tc_unit (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [7:0] i_load_val,
    input wire logic i_dec,
    output logic [7:0] o_count
);
    // Load wins over a decrement in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= 8'h00;
        end else if (i_load) begin
            o_count <= i_load_val;
        end else if (i_dec) begin
            o_count <= o_count - 8'h01;
        end
    end
endmodule
`default_nettype wire

// file: verilog/timer_port_mode.sv
// Timer bank, port 1 and port 2 control with mode and direction registers.
// Assumes a synchronous register port strobed for one cycle per access;
// port pins arrive asynchronously and are synchronised here.
//
// Notes on behaviour
// - Mode codes pick nibble, handshake, reserved, test.
// - Test mode puts baud clock on port1 bit4 if that pin is an output and internal baud is chosen.
// - Handshake mode moves level 7 to port 2.
// - Event select counts rising edges on pins 2/3.
// - Event select low: internal timer, pin free.
// - Retrigger: timer 5 write loads save, stops.
// - Trigger falling edge loads save and runs.
// - Reset clears save, timer 5 stays stopped.
// - Zero reached: request, clear enable, keep counting.
// - Cascade bits join timers 2/4 and 3/5.
// - Cascaded trigger presets timer 3 to ones.
// - Cascaded pair with event select counts pins.
// - Cascades vacate one level each.
// - Request on 1 to 0, or 0001 to 0000.
// - Direction bit high makes pin an output.
// - Handshake uses pin 0 strobe, pin 1 full.
// - Port 2 write lowers full, acknowledge raises it.
// - Strobe lowers full, latches on rise, read raises.
// - Soft reset raises the full line, clears enables.
// - Timers count down continuously once running.
// - Port 2 read: strobe latch in input handshake, else pins for inputs, latch otherwise.
`timescale 1ns/1ps
`default_nettype none
module timer_port_mode (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_baud_clk,
    input wire logic [7:0] i_p1_in,
    input wire logic [7:0] i_p2_in,
    output logic [7:0] o_rdata,
    output logic [7:0] o_p1_out,
    output logic [7:0] o_p1_oe,
    output logic [7:0] o_p2_out,
    output logic [7:0] o_p2_oe,
    output logic [7:0] o_irq_req
);
    tpm_pkg::mode_s mode;
    logic [7:0] p1_dir, p1_latch, p2_latch, p2_captured, ien, save5;
    logic [3:0] baud_select_field;
    logic [7:0] p1_s1, p1_s2, p1_s3, p2_s1, p2_s2;
    logic [5:0] tick_cnt;
    logic tick, full_flag, soft_rst;
    logic [4:0] run;
    logic [7:0] cnt [1:5];
    logic [5:1] ld, dec;
    logic [7:0] ld_val [1:5];
    logic [7:0] hit, next_rdata, next_p1_out, next_p1_oe, next_p2_oe;
    logic hs_mode, hs_in, hs_out, test_mode, wr_t, ev2, ev3, trig5, stb_fall, stb_rise;
    logic hs_event;
    logic [2:0] tsel;

    function automatic logic is_one(input logic [7:0] v);
        return v == tpm_pkg::CNT_ONE;
    endfunction

    // Two-stage synchronisers, third stage only for edge detection
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            p1_s1 <= 8'hff;
            p1_s2 <= 8'hff;
            p1_s3 <= 8'hff;
            p2_s1 <= 8'h00;
            p2_s2 <= 8'h00;
        end else begin
            p1_s1 <= i_p1_in;
            p1_s2 <= p1_s1;
            p1_s3 <= p1_s2;
            p2_s1 <= i_p2_in;
            p2_s2 <= p2_s1;
        end
    end

    assign hs_in = mode.port2_mode == tpm_pkg::P2_HS_IN;
    assign hs_out = mode.port2_mode == tpm_pkg::P2_HS_OUT;
    assign hs_mode = hs_in | hs_out;
    assign test_mode = mode.port2_mode == tpm_pkg::P2_TEST;
    assign ev2 = p1_s2[tpm_pkg::P1_EV2] & ~p1_s3[tpm_pkg::P1_EV2];
    assign ev3 = p1_s2[tpm_pkg::P1_EV3] & ~p1_s3[tpm_pkg::P1_EV3];
    assign trig5 = mode.timer5_retrigger_enable
        & ~p1_s2[tpm_pkg::P1_TRIG5] & p1_s3[tpm_pkg::P1_TRIG5];
    assign stb_fall = ~p1_s2[tpm_pkg::P1_STROBE] & p1_s3[tpm_pkg::P1_STROBE];
    assign stb_rise = p1_s2[tpm_pkg::P1_STROBE] & ~p1_s3[tpm_pkg::P1_STROBE];
    assign soft_rst = i_wr && i_addr == tpm_pkg::REG_CMD3
        && i_wdata[tpm_pkg::CMD3_SET_BIT] && i_wdata[tpm_pkg::CMD3_RST_BIT];

    // Operating tick, 39 cycles of 25 ns as close to 1.024 MHz as whole cycles allow
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_cnt <= 6'h00;
        end else if (tick_cnt == tpm_pkg::TICK_LAST) begin
            tick_cnt <= 6'h00;
        end else begin
            tick_cnt <= tick_cnt + 6'h01;
        end
    end
    assign tick = tick_cnt == tpm_pkg::TICK_LAST;

    // Configuration registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= tpm_pkg::MODE_RESET;
            p1_dir <= tpm_pkg::DIR_RESET;
            baud_select_field <= 4'h0;
            p1_latch <= 8'h00;
            p2_latch <= 8'h00;
        end else if (i_wr) begin
            if (i_addr == tpm_pkg::REG_MODE) begin
                mode <= i_wdata;
            end else if (i_addr == tpm_pkg::REG_P1DIR) begin
                p1_dir <= i_wdata;
            end else if (i_addr == tpm_pkg::REG_CMD2) begin
                baud_select_field <= i_wdata[3:0];
            end else if (i_addr == tpm_pkg::REG_PORT1) begin
                p1_latch <= i_wdata;
            end else if (i_addr == tpm_pkg::REG_PORT2) begin
                p2_latch <= i_wdata;
            end
        end
    end

    // Timer register decode
    assign wr_t = i_wr && i_addr >= tpm_pkg::REG_TIMER1 && i_addr <= tpm_pkg::REG_TIMER5;
    assign tsel = 3'(i_addr - tpm_pkg::REG_TIMER1 + 4'h1);

    // Save register holds the retrigger start value
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            save5 <= tpm_pkg::SAVE5_RESET;
        end else if (wr_t && tsel == 3'd5 && mode.timer5_retrigger_enable) begin
            save5 <= i_wdata;
        end
    end

    // Load strobes and values
    always_comb begin
        for (int i = 1; i <= 5; i++) begin
            ld[i] = wr_t && tsel == 3'(i);
            ld_val[i] = i_wdata;
        end
        // Writing the high byte of a pair presets the low byte
        if (mode.cascade_pair_2_4 && wr_t && tsel == 3'd4) begin
            ld[2] = 1'b1;
            ld_val[2] = tpm_pkg::CNT_ALL_ONES;
        end
        if (mode.cascade_pair_3_5 && wr_t && tsel == 3'd5) begin
            ld[3] = 1'b1;
            ld_val[3] = tpm_pkg::CNT_ALL_ONES;
        end
        if (mode.timer5_retrigger_enable) begin
            ld[5] = trig5;
            ld_val[5] = save5;
            if (mode.cascade_pair_3_5 && trig5) begin
                ld[3] = 1'b1;
                ld_val[3] = tpm_pkg::CNT_ALL_ONES;
            end
        end
    end

    // Run flags; timer 5 stays stopped until a write or trigger
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            run <= 5'h00;
        end else begin
            for (int i = 1; i <= 4; i++) begin
                if (ld[i]) begin
                    run[i-1] <= 1'b1;
                end
            end
            if (mode.timer5_retrigger_enable) begin
                if (trig5) begin
                    run[4] <= 1'b1;
                end else if (ld[5] || (wr_t && tsel == 3'd5)) begin
                    run[4] <= 1'b0;
                end
                if (mode.cascade_pair_3_5 && wr_t && tsel == 3'd5 && !trig5) begin
                    run[2] <= 1'b0;
                end
            end else if (ld[5]) begin
                run[4] <= 1'b1;
            end
        end
    end

    // Count sources; low bytes clock the high bytes when cascaded
    always_comb begin
        dec[1] = run[0] & tick;
        dec[2] = run[1] & (mode.counter2_event_select ? ev2 : tick);
        dec[3] = run[2] & (mode.counter3_event_select ? ev3 : tick);
        if (mode.cascade_pair_2_4) begin
            dec[4] = dec[2] && cnt[2] == 8'h00;
        end else begin
            dec[4] = run[3] & tick;
        end
        if (mode.cascade_pair_3_5) begin
            dec[5] = dec[3] && cnt[3] == 8'h00;
        end else begin
            dec[5] = run[4] & tick;
        end
    end

    genvar g;
    generate
        for (g = 1; g <= 5; g++) begin : g_tc
            tc_unit u_tc (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_load(ld[g]),
                .i_load_val(ld_val[g]),
                .i_dec(dec[g]),
                .o_count(cnt[g])
            );
        end
    endgenerate

    // Handshake flag, high when idle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            full_flag <= 1'b1;
            p2_captured <= 8'h00;
        end else begin
            if (soft_rst) begin
                full_flag <= 1'b1;
            end else if (hs_out) begin
                if (i_wr && i_addr == tpm_pkg::REG_PORT2) begin
                    full_flag <= 1'b0;
                end else if (stb_fall) begin
                    full_flag <= 1'b1;
                end
            end else if (hs_in) begin
                // The strobe edge wins over a concurrent host read
                if (stb_fall) begin
                    full_flag <= 1'b0;
                end else if (i_rd && i_addr == tpm_pkg::REG_PORT2) begin
                    full_flag <= 1'b1;
                end
            end else begin
                full_flag <= 1'b1;
            end
            if (hs_in && stb_rise) begin
                p2_captured <= p2_s2;
            end
        end
    end
    assign hs_event = (hs_in & stb_rise) | (hs_out & stb_fall);

    // Interrupt hits per level, with cascade reassignment
    always_comb begin
        hit = 8'h00;
        hit[tpm_pkg::LVL_T1] = dec[1] & is_one(cnt[1]);
        if (mode.cascade_pair_2_4) begin
            // Pair 2/4 signals on the timer 4 level only
            hit[tpm_pkg::LVL_T4] = dec[2] & is_one(cnt[2]) & (cnt[4] == 8'h00);
        end else begin
            hit[tpm_pkg::LVL_T2] = dec[2] & is_one(cnt[2]);
            hit[tpm_pkg::LVL_T4] = dec[4] & is_one(cnt[4]);
        end
        if (mode.cascade_pair_3_5) begin
            hit[tpm_pkg::LVL_T3] = dec[3] & is_one(cnt[3]) & (cnt[5] == 8'h00);
        end else begin
            hit[tpm_pkg::LVL_T3] = dec[3] & is_one(cnt[3]);
            hit[tpm_pkg::LVL_T5] = ~hs_mode & dec[5] & is_one(cnt[5]);
        end
        if (hs_mode) begin
            hit[tpm_pkg::LVL_T5] = hs_event;
        end
    end

    // Enables: hardware clear on request, software set and clear
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ien <= 8'h00;
            o_irq_req <= 8'h00;
        end else begin
            o_irq_req <= hit & ien & {8{~soft_rst}};
            if (soft_rst) begin
                ien <= 8'h00;
            end else if (i_wr && i_addr == tpm_pkg::REG_IEN_SET) begin
                ien <= (ien | i_wdata) & ~(hit & ien);
            end else if (i_wr && i_addr == tpm_pkg::REG_IEN_CLR) begin
                ien <= ien & ~i_wdata & ~(hit & ien);
            end else begin
                ien <= ien & ~(hit & ien);
            end
        end
    end

    // Pin directions and drive values
    always_comb begin
        next_p1_oe = p1_dir;
        next_p1_out = p1_latch;
        if (hs_mode) begin
            next_p1_oe[tpm_pkg::P1_STROBE] = 1'b0;
            next_p1_oe[tpm_pkg::P1_FULL] = 1'b1;
            next_p1_out[tpm_pkg::P1_FULL] = full_flag;
        end
        if (mode.counter2_event_select) begin
            next_p1_oe[tpm_pkg::P1_EV2] = 1'b0;
        end
        if (mode.counter3_event_select) begin
            next_p1_oe[tpm_pkg::P1_EV3] = 1'b0;
        end
        if (mode.timer5_retrigger_enable) begin
            next_p1_oe[tpm_pkg::P1_TRIG5] = 1'b0;
        end
        // Baud clock only with the pin as output and the internal generator chosen
        if (test_mode && p1_dir[tpm_pkg::P1_BAUD]
                && baud_select_field >= tpm_pkg::BAUD_MIN_INTERNAL) begin
            next_p1_out[tpm_pkg::P1_BAUD] = i_baud_clk;
        end
        case (mode.port2_mode)
            tpm_pkg::P2_HS_IN: next_p2_oe = 8'h00;
            tpm_pkg::P2_HS_OUT: next_p2_oe = 8'hff;
            tpm_pkg::P2_RSVD: next_p2_oe = 8'h00;
            tpm_pkg::P2_TEST: next_p2_oe = 8'h00;
            default: next_p2_oe = {{4{mode.port2_mode[1]}}, {4{mode.port2_mode[0]}}};
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_p1_oe <= 8'h00;
            o_p1_out <= 8'h00;
            o_p2_oe <= 8'h00;
            o_p2_out <= 8'h00;
        end else begin
            o_p1_oe <= next_p1_oe;
            o_p1_out <= next_p1_out;
            o_p2_oe <= next_p2_oe;
            o_p2_out <= p2_latch;
        end
    end

    // Read data, captured on the read strobe
    always_comb begin
        next_rdata = 8'h00;
        if (i_addr == tpm_pkg::REG_MODE) begin
            next_rdata = mode;
        end else if (i_addr == tpm_pkg::REG_P1DIR) begin
            next_rdata = p1_dir;
        end else if (i_addr == tpm_pkg::REG_IEN_SET) begin
            next_rdata = ien;
        end else if (i_addr == tpm_pkg::REG_PORT1) begin
            next_rdata = (o_p1_oe & o_p1_out) | (~o_p1_oe & p1_s2);
        end else if (i_addr == tpm_pkg::REG_PORT2) begin
            next_rdata = hs_in ? p2_captured
                : ((o_p2_oe & p2_latch) | (~o_p2_oe & p2_s2));
        end else if (i_addr >= tpm_pkg::REG_TIMER1 && i_addr <= tpm_pkg::REG_TIMER5) begin
            next_rdata = cnt[tsel];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// file: verilog/tpm_pkg.sv
// Constants and types shared by the timer and port mode controller.
// Assumes a single 40 MHz clock and an 8-bit register port with a 4-bit index.
package tpm_pkg;
    // Register indices on the register port
    localparam logic [3:0] REG_CMD2 = 4'h1;
    localparam logic [3:0] REG_CMD3 = 4'h2;
    localparam logic [3:0] REG_MODE = 4'h3;
    localparam logic [3:0] REG_P1DIR = 4'h4;
    localparam logic [3:0] REG_IEN_SET = 4'h5;
    localparam logic [3:0] REG_IEN_CLR = 4'h6;
    localparam logic [3:0] REG_PORT1 = 4'h8;
    localparam logic [3:0] REG_PORT2 = 4'h9;
    localparam logic [3:0] REG_TIMER1 = 4'ha;
    localparam logic [3:0] REG_TIMER5 = 4'he;

    // Command register 3 bit positions
    localparam int CMD3_SET_BIT = 7;
    localparam int CMD3_RST_BIT = 0;

    // Port 2 mode codes
    localparam logic [2:0] P2_NIB_II = 3'h0;
    localparam logic [2:0] P2_NIB_OO = 3'h3;
    localparam logic [2:0] P2_HS_IN = 3'h4;
    localparam logic [2:0] P2_HS_OUT = 3'h5;
    localparam logic [2:0] P2_RSVD = 3'h6;
    localparam logic [2:0] P2_TEST = 3'h7;

    // Port 1 pin roles
    localparam int P1_STROBE = 0;
    localparam int P1_FULL = 1;
    localparam int P1_EV2 = 2;
    localparam int P1_EV3 = 3;
    localparam int P1_BAUD = 4;
    localparam int P1_TRIG5 = 5;

    // Interrupt levels
    localparam int LVL_T1 = 0;
    localparam int LVL_T2 = 1;
    localparam int LVL_T3 = 3;
    localparam int LVL_T4 = 6;
    localparam int LVL_T5 = 7;

    localparam logic [3:0] BAUD_MIN_INTERNAL = 4'h3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] SAVE5_RESET = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_ALL_ONES = 8'hff;

    // Operating tick: 1.024 MHz derived from the 40 MHz clock
    localparam int CLK_KHZ = 40000;
    localparam int OP_CLK_KHZ = 1024;
    localparam int TICK_CYCLES = CLK_KHZ / OP_CLK_KHZ;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

    typedef struct packed {
        logic cascade_pair_3_5;
        logic cascade_pair_2_4;
        logic timer5_retrigger_enable;
        logic counter3_event_select;
        logic counter2_event_select;
        logic [2:0] port2_mode;
    } mode_s;
endpackage
